// [src/loader_map.svh]
`ifndef LOADER_MAP_SVH
`define LOADER_MAP_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define REF_CLK_MHZ 100
`define CFG_SCLK_DIV 72
`define RESET_SEQ_MS 800
`define RESET_TAIL_CYCLES 64
`define FLASH_HALF_CYCLES 8

// ----------------------------------------------------------------------
// Configuration ROM framing
// ----------------------------------------------------------------------
`define CFG_CMD 11'h600
`define CFG_CMD_BITS 11
`define CFG_TURN_CLOCKS 1
`define CFG_DATA_BITS 112

// ----------------------------------------------------------------------
// Configuration field positions
// ----------------------------------------------------------------------
`define FLD_MULT_MSB 111
`define FLD_MULT_LSB 104
`define FLD_HOSTDIV_MSB 103
`define FLD_HOSTDIV_LSB 96
`define FLD_DDRDIV_MSB 95
`define FLD_DDRDIV_LSB 88
`define FLD_SDRDIV_MSB 87
`define FLD_SDRDIV_LSB 80
`define FLD_FETCH_FLASH 79
`define FLD_FLASH_SINGLE 78
`define FLD_FWLEN_MSB 77
`define FLD_FWLEN_LSB 58
`define FLD_MODE_MSB 57

// ----------------------------------------------------------------------
// Boot flash opcodes and reset values
// ----------------------------------------------------------------------
`define FLASH_OP_READ 8'h03
`define FLASH_OP_WEN 8'h06
`define FLASH_OP_PROG 8'h02
`define VCODE_RESET 5'h0E

`endif

// [src/loader_pkg.sv]
`default_nettype none

package loader_pkg;

   typedef enum logic [1:0] {
      XFER_READ,
      XFER_WEN,
      XFER_PROG
   } xfer_kind_t;

   typedef enum logic [3:0] {
      ST_PROTECT,
      ST_WAIT_HOST,
      ST_READ_CFG,
      ST_WAIT_MEM,
      ST_COPY_READ,
      ST_COPY_WRITE,
      ST_WAIT_RESET,
      ST_FETCH,
      ST_RUN,
      ST_PROG_WEN,
      ST_PROG_WR
   } loader_state_t;

endpackage

`default_nettype wire

// [src/flash_xfer_if.sv]
`default_nettype none

interface flash_xfer_if;
   logic req;
   loader_pkg::xfer_kind_t kind;
   logic [19:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic done;

   modport requester (output req, kind, addr, wdata, input rdata, done);
   modport servant (input req, kind, addr, wdata, output rdata, done);
endinterface

`default_nettype wire

// [src/cfg_rom_reader.sv]
`include "loader_map.svh"
`default_nettype none

module cfg_rom_reader (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic abort,
   input wire logic start,
   input wire logic sdata_in,
   output logic sclk,
   output logic sdata_out,
   output logic sdata_oe,
   output logic done,
   output logic [`CFG_DATA_BITS-1:0] bits
);
   localparam logic [5:0] HALF_LAST = 6'(`CFG_SCLK_DIV / 2 - 1);
   localparam logic [`CFG_CMD_BITS-1:0] CMD_WORD = `CFG_CMD;
   localparam logic [6:0] FIRST_DATA = 7'(`CFG_CMD_BITS + `CFG_TURN_CLOCKS);
   localparam logic [6:0] LAST_CLK = 7'(`CFG_CMD_BITS + `CFG_TURN_CLOCKS
                                        + `CFG_DATA_BITS - 1);

   logic active;
   logic [5:0] div;
   logic [6:0] idx;
   logic [`CFG_CMD_BITS-1:0] cmd;

   wire edge_now = active && (div == HALF_LAST);
   wire rising = edge_now && !sclk;
   wire falling = edge_now && sclk;
   wire [6:0] next_idx = idx + 7'h01;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active <= 1'b0;
         div <= 6'h00;
         idx <= 7'h00;
         sclk <= 1'b0;
         sdata_out <= 1'b0;
         sdata_oe <= 1'b0;
         done <= 1'b0;
         cmd <= 11'h000;
         bits <= '0;
      end
      else if (abort)
      begin
         active <= 1'b0;
         sclk <= 1'b0;
         sdata_oe <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= falling && (idx == LAST_CLK);
         div <= (edge_now || !active) ? 6'h00 : div + 6'h01;
         if (edge_now)
            sclk <= !sclk;
         if (start && !active)
         begin
            // MSB of the read command is on the line before the first rise.
            active <= 1'b1;
            idx <= 7'h00;
            sdata_oe <= 1'b1;
            sdata_out <= CMD_WORD[`CFG_CMD_BITS-1];
            cmd <= CMD_WORD << 1;
         end
         if (rising && idx >= FIRST_DATA)
            bits <= {bits[`CFG_DATA_BITS-2:0], sdata_in};
         if (falling)
         begin
            active <= idx != LAST_CLK;
            idx <= next_idx;
            sdata_out <= cmd[`CFG_CMD_BITS-1] && next_idx < 7'(`CFG_CMD_BITS);
            cmd <= cmd << 1;
            sdata_oe <= next_idx < 7'(`CFG_CMD_BITS);
         end
      end
   end
endmodule // cfg_rom_reader

`default_nettype wire

// [src/boot_flash_port.sv]
`include "loader_map.svh"
`default_nettype none

module boot_flash_port (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic abort,
   input wire logic single_device,
   flash_xfer_if.servant xfer,
   input wire logic data_in,
   output logic sclk,
   output logic select0_n,
   output logic select1_n,
   output logic data_out
);
   logic active;
   logic [3:0] div;
   logic [5:0] cnt;
   logic [5:0] last;
   logic [39:0] sr;

   wire edge_now = active && (div == 4'(`FLASH_HALF_CYCLES - 1));
   wire upper = xfer.addr[19];
   // Two half-size parts split on the top address bit, or one whole part.
   wire [23:0] dev_addr = {4'h0, single_device & upper, xfer.addr[18:0]};
   wire [7:0] op = (xfer.kind == loader_pkg::XFER_READ) ? `FLASH_OP_READ :
                   (xfer.kind == loader_pkg::XFER_WEN) ? `FLASH_OP_WEN :
                   `FLASH_OP_PROG;
   wire [5:0] len = (xfer.kind == loader_pkg::XFER_WEN) ? 6'h08 : 6'h28;
   wire pick1 = !single_device && upper;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         active <= 1'b0;
         div <= 4'h0;
         cnt <= 6'h00;
         last <= 6'h00;
         sr <= '0;
         sclk <= 1'b0;
         select0_n <= 1'b1;
         select1_n <= 1'b1;
         data_out <= 1'b0;
         xfer.done <= 1'b0;
         xfer.rdata <= 8'h00;
      end
      else if (abort)
      begin
         active <= 1'b0;
         sclk <= 1'b0;
         select0_n <= 1'b1;
         select1_n <= 1'b1;
         xfer.done <= 1'b0;
      end
      else
      begin
         xfer.done <= edge_now && sclk && cnt == last;
         div <= (edge_now || !active) ? 4'h0 : div + 4'h1;
         if (xfer.req && !active)
         begin
            active <= 1'b1;
            cnt <= 6'h00;
            last <= len - 6'h01;
            sr <= {op, dev_addr, xfer.wdata} << 1;
            data_out <= op[7];
            select0_n <= pick1;
            select1_n <= !pick1;
         end
         if (edge_now)
            sclk <= !sclk;
         if (edge_now && !sclk)
            xfer.rdata <= {xfer.rdata[6:0], data_in};
         if (edge_now && sclk)
         begin
            cnt <= cnt + 6'h01;
            data_out <= sr[39];
            sr <= sr << 1;
            if (cnt == last)
            begin
               active <= 1'b0;
               select0_n <= 1'b1;
               select1_n <= 1'b1;
            end
         end
      end
   end
endmodule // boot_flash_port

`default_nettype wire

// [src/power_on_config_rom_loader.sv]
`include "loader_map.svh"
`default_nettype none

module power_on_config_rom_loader #(
   parameter int RESET_SEQ_CYCLES = `RESET_SEQ_MS * 1000 * `REF_CLK_MHZ
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic power_good,
   input wire logic host_bus_reset_n,
   input wire logic processor_reset_n,
   input wire logic mem_init_done,
   output logic config_rom_serial_clock,
   input wire logic config_rom_serial_data_in,
   output logic config_rom_serial_data_out,
   output logic config_rom_serial_data_oe,
   output logic boot_flash_select0_n,
   output logic boot_flash_select1_n,
   output logic boot_flash_serial_clock,
   input wire logic boot_flash_data_in,
   output logic boot_flash_data_out,
   input wire logic [4:0] core_voltage_code_in,
   output logic [4:0] core_voltage_code_out,
   output logic [4:0] core_voltage_code_oe,
   output logic [4:0] core_voltage_readback,
   input wire logic vcode_load,
   input wire logic [4:0] vcode_value,
   input wire logic flash_prog_req,
   input wire logic [19:0] flash_prog_addr,
   input wire logic [7:0] flash_prog_data,
   output logic flash_prog_done,
   output logic [7:0] core_multiplier_x2,
   output logic [7:0] host_bus_divisor,
   output logic [7:0] ddr_clock_divisor,
   output logic [7:0] sdr_clock_divisor,
   output logic [`FLD_MODE_MSB:0] config_mode_bits,
   output logic config_loaded,
   output logic mem_wr_valid,
   output logic [19:0] mem_wr_addr,
   output logic [7:0] mem_wr_data,
   output logic internal_reset_active,
   output logic first_fetch,
   output logic fetch_from_flash
);
   localparam int SEQ_TOTAL = RESET_SEQ_CYCLES + `RESET_TAIL_CYCLES;
   localparam int NSYNC = 10;

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   wire [NSYNC-1:0] pins_raw = {core_voltage_code_in, boot_flash_data_in,
                                config_rom_serial_data_in, processor_reset_n,
                                host_bus_reset_n, power_good};
   logic [NSYNC-1:0] pins;

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         logic s1;
         logic s2;
         logic s3;
         always_ff @(posedge ref_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
               pins[gi] <= 1'b0;
            end
            else
            begin
               s1 <= pins_raw[gi];
               s2 <= s1;
               s3 <= s2;
               if (s2 == s3)
                  pins[gi] <= s3;
            end
         end
      end
   endgenerate

   wire pg = pins[0];
   wire host_rel = pins[1];
   wire proc_rel = pins[2];
   wire cfg_din = pins[3];
   wire flash_din = pins[4];
   wire [4:0] vcode_pins = pins[9:5];
   wire abort = !pg;

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   loader_pkg::loader_state_t state;
   loader_pkg::loader_state_t next_state;
   logic xfer_req;
   logic [19:0] copy_addr;
   logic [19:0] fw_len;
   logic flash_single;
   logic [19:0] prog_addr;
   logic [7:0] prog_data;
   logic proc_prev;
   logic seq_run;
   logic seq_done;
   logic [27:0] seq_cnt;
   logic cfg_done;
   logic [`CFG_DATA_BITS-1:0] cfg_bits;

   flash_xfer_if xfer ();

   wire cfg_start = (state == loader_pkg::ST_WAIT_HOST) && host_rel;
   wire copy_last = (copy_addr + 20'h00001) == fw_len;
   wire seq_end = seq_run && (seq_cnt == 28'(SEQ_TOTAL - 1));
   wire next_req = (next_state != state) &&
                   (next_state == loader_pkg::ST_COPY_READ ||
                    next_state == loader_pkg::ST_PROG_WEN ||
                    next_state == loader_pkg::ST_PROG_WR);
   wire in_run = (state == loader_pkg::ST_RUN);
   wire prog_phase = (state == loader_pkg::ST_PROG_WEN) ||
                     (state == loader_pkg::ST_PROG_WR);

   always_comb
   begin
      next_state = state;
      case (state)
         loader_pkg::ST_PROTECT:
            if (pg)
               next_state = loader_pkg::ST_WAIT_HOST;
         loader_pkg::ST_WAIT_HOST:
            if (host_rel)
               next_state = loader_pkg::ST_READ_CFG;
         loader_pkg::ST_READ_CFG:
            if (cfg_done)
               next_state = loader_pkg::ST_WAIT_MEM;
         loader_pkg::ST_WAIT_MEM:
            if (mem_init_done)
               next_state = (fw_len == 20'h00000) ?
                            loader_pkg::ST_WAIT_RESET :
                            loader_pkg::ST_COPY_READ;
         loader_pkg::ST_COPY_READ:
            if (xfer.done)
               next_state = loader_pkg::ST_COPY_WRITE;
         loader_pkg::ST_COPY_WRITE:
            next_state = copy_last ? loader_pkg::ST_WAIT_RESET :
                         loader_pkg::ST_COPY_READ;
         loader_pkg::ST_WAIT_RESET:
            if (seq_done)
               next_state = loader_pkg::ST_FETCH;
         loader_pkg::ST_FETCH:
            next_state = loader_pkg::ST_RUN;
         loader_pkg::ST_RUN:
            if (flash_prog_req)
               next_state = loader_pkg::ST_PROG_WEN;
         loader_pkg::ST_PROG_WEN:
            if (xfer.done)
               next_state = loader_pkg::ST_PROG_WR;
         loader_pkg::ST_PROG_WR:
            if (xfer.done)
               next_state = loader_pkg::ST_RUN;
         default:
            next_state = loader_pkg::ST_PROTECT;
      endcase
      if (!pg)
         next_state = loader_pkg::ST_PROTECT;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= loader_pkg::ST_PROTECT;
         xfer_req <= 1'b0;
      end
      else
      begin
         state <= next_state;
         xfer_req <= next_req;
      end
   end

   // ------------------------------------------------------------------
   // Flash requests
   // ------------------------------------------------------------------
   assign xfer.req = xfer_req;
   assign xfer.kind = (state == loader_pkg::ST_PROG_WEN) ? loader_pkg::XFER_WEN :
                      (state == loader_pkg::ST_PROG_WR) ? loader_pkg::XFER_PROG :
                      loader_pkg::XFER_READ;
   assign xfer.addr = prog_phase ? prog_addr : copy_addr;
   assign xfer.wdata = prog_data;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         copy_addr <= 20'h00000;
         prog_addr <= 20'h00000;
         prog_data <= 8'h00;
      end
      else
      begin
         if (state == loader_pkg::ST_WAIT_MEM)
            copy_addr <= 20'h00000;
         else if (state == loader_pkg::ST_COPY_WRITE)
            copy_addr <= copy_addr + 20'h00001;
         if (in_run && flash_prog_req)
         begin
            prog_addr <= flash_prog_addr;
            prog_data <= flash_prog_data;
         end
      end
   end

   // ------------------------------------------------------------------
   // Configuration capture
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core_multiplier_x2 <= 8'h00;
         host_bus_divisor <= 8'h00;
         ddr_clock_divisor <= 8'h00;
         sdr_clock_divisor <= 8'h00;
         fetch_from_flash <= 1'b0;
         flash_single <= 1'b0;
         fw_len <= 20'h00000;
         config_mode_bits <= '0;
         config_loaded <= 1'b0;
      end
      else if (abort)
         config_loaded <= 1'b0;
      else if (cfg_done)
      begin
         core_multiplier_x2 <= cfg_bits[`FLD_MULT_MSB:`FLD_MULT_LSB];
         host_bus_divisor <= cfg_bits[`FLD_HOSTDIV_MSB:`FLD_HOSTDIV_LSB];
         ddr_clock_divisor <= cfg_bits[`FLD_DDRDIV_MSB:`FLD_DDRDIV_LSB];
         sdr_clock_divisor <= cfg_bits[`FLD_SDRDIV_MSB:`FLD_SDRDIV_LSB];
         fetch_from_flash <= cfg_bits[`FLD_FETCH_FLASH];
         flash_single <= cfg_bits[`FLD_FLASH_SINGLE];
         fw_len <= cfg_bits[`FLD_FWLEN_MSB:`FLD_FWLEN_LSB];
         config_mode_bits <= cfg_bits[`FLD_MODE_MSB:0];
         config_loaded <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // Internal reset sequence
   // ------------------------------------------------------------------
   // The timer starts on the processor reset release, in parallel with
   // the firmware copy; fetch waits for both to finish.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         proc_prev <= 1'b0;
         seq_run <= 1'b0;
         seq_done <= 1'b0;
         seq_cnt <= 28'h0000000;
      end
      else if (abort)
      begin
         proc_prev <= 1'b0;
         seq_run <= 1'b0;
         seq_done <= 1'b0;
      end
      else
      begin
         proc_prev <= proc_rel;
         if (proc_rel && !proc_prev)
         begin
            seq_run <= 1'b1;
            seq_cnt <= 28'h0000000;
         end
         else if (seq_end)
         begin
            seq_run <= 1'b0;
            seq_done <= 1'b1;
         end
         else if (seq_run)
            seq_cnt <= seq_cnt + 28'h0000001;
      end
   end

   // ------------------------------------------------------------------
   // Status outputs and core voltage code
   // ------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mem_wr_valid <= 1'b0;
         mem_wr_addr <= 20'h00000;
         mem_wr_data <= 8'h00;
         first_fetch <= 1'b0;
         flash_prog_done <= 1'b0;
         internal_reset_active <= 1'b1;
         core_voltage_readback <= 5'h00;
      end
      else
      begin
         mem_wr_valid <= (state == loader_pkg::ST_COPY_READ) &&
                         xfer.done && pg;
         if (state == loader_pkg::ST_COPY_READ && xfer.done)
         begin
            mem_wr_addr <= copy_addr;
            mem_wr_data <= xfer.rdata;
         end
         first_fetch <= (state == loader_pkg::ST_FETCH) && pg;
         flash_prog_done <= (state == loader_pkg::ST_PROG_WR) &&
                            xfer.done && pg;
         internal_reset_active <= !(in_run || prog_phase) ||
                                  !pg;
         core_voltage_readback <= vcode_pins;
      end
   end

   // Open drain: a zero bit is driven low, a one bit is released.
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         core_voltage_code_out <= 5'h00;
         core_voltage_code_oe <= ~`VCODE_RESET;
      end
      else if (abort)
         core_voltage_code_oe <= ~`VCODE_RESET;
      else if ((in_run || prog_phase) && vcode_load)
         core_voltage_code_oe <= ~vcode_value;
   end

   // ------------------------------------------------------------------
   // Serial engines
   // ------------------------------------------------------------------
   cfg_rom_reader u_cfg (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .abort(abort),
      .start(cfg_start),
      .sdata_in(cfg_din),
      .sclk(config_rom_serial_clock),
      .sdata_out(config_rom_serial_data_out),
      .sdata_oe(config_rom_serial_data_oe),
      .done(cfg_done),
      .bits(cfg_bits)
   );

   boot_flash_port u_flash (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .abort(abort),
      .single_device(flash_single),
      .xfer(xfer.servant),
      .data_in(flash_din),
      .sclk(boot_flash_serial_clock),
      .select0_n(boot_flash_select0_n),
      .select1_n(boot_flash_select1_n),
      .data_out(boot_flash_data_out)
   );
endmodule // power_on_config_rom_loader

`default_nettype wire

// [sim/loader_props.sv]
`default_nettype none

module loader_props #(
   parameter int RESET_SEQ_CYCLES = 200
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic power_good,
   input wire logic processor_reset_n,
   input wire logic config_rom_serial_clock,
   input wire logic config_rom_serial_data_out,
   input wire logic config_rom_serial_data_oe,
   input wire logic [4:0] core_voltage_code_oe,
   input wire logic config_loaded,
   input wire logic internal_reset_active
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sq;
   logic [7:0] hi, nc, nd;
   int since;
   wire sc = config_rom_serial_clock;
   wire oe = config_rom_serial_data_oe;
   wire rise = sc & ~sq;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sq <= 1'b0;
         hi <= 8'h00;
         nc <= 8'h00;
         nd <= 8'h00;
         since <= 0;
      end
      else
      begin
         sq <= sc;
         hi <= sc ? hi + 8'h01 : 8'h00;
         nc <= !oe ? 8'h00 : nc + {7'h00, rise};
         nd <= oe ? 8'h00 : nd + {7'h00, rise};
         since <= processor_reset_n ? since + 1 : 0;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_pg_low;
      !power_good [*8];
   endsequence
   a_protect_idle:
      assert property (s_pg_low |-> !config_loaded && !oe)
      else $error("loader active without power good");
   a_vcode_default:
      assert property (s_pg_low |-> core_voltage_code_oe == 5'h11)
      else $error("voltage code not at default");
   a_sclk_divide:
      assert property ($fell(sc) |-> hi == 8'h24)
      else $error("serial clock high time wrong");
   a_cmd_length:
      assert property ($fell(oe) |-> nc == 8'h0B)
      else $error("command clock count wrong");
   a_turn_edge:
      assert property ($fell(oe) |-> $fell(sc))
      else $error("data line released off a falling edge");
   a_data_count:
      assert property ($rose(config_loaded) |-> nd == 8'h71)
      else $error("data clock count wrong");
   a_out_stable:
      assert property (sc && $past(sc) |-> $stable(config_rom_serial_data_out))
      else $error("data out moved while clock high");
   a_reset_span:
      assert property ($fell(internal_reset_active) |->
         since >= RESET_SEQ_CYCLES + 64)
      else $error("internal reset ended early");
endmodule // loader_props

bind power_on_config_rom_loader loader_props #(
   .RESET_SEQ_CYCLES(RESET_SEQ_CYCLES)
) props (
   .ref_clk, .rst_n, .power_good, .processor_reset_n,
   .config_rom_serial_clock, .config_rom_serial_data_out,
   .config_rom_serial_data_oe, .core_voltage_code_oe,
   .config_loaded, .internal_reset_active
);

`default_nettype wire

// [sim/cfg_rom_model.sv]
`default_nettype none

module cfg_rom_model #(
   parameter logic [111:0] IMAGE = '0
) (
   input wire logic sclk,
   input wire logic data_out,
   input wire logic data_oe,
   output logic data_in,
   output logic [10:0] cmd
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   logic q = 1'b0;
   assign data_in = data_oe ? data_out : q;
   initial cmd = 11'h000;
   always @(posedge sclk)
   begin
      if (data_oe)
         cmd <= {cmd[9:0], data_out};
      cnt <= cnt + 1;
   end
   // Outside the data phase the released line keeps changing level.
   always @(negedge sclk)
   begin
      if (cnt >= 12 && cnt < 124)
         q <= IMAGE[123 - cnt];
      else
         q <= ~q;
   end
endmodule // cfg_rom_model

`default_nettype wire

// [sim/power_on_config_rom_loader_test.sv]
`default_nettype none

module power_on_config_rom_loader_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEQ = 200;
   localparam logic [111:0] IMG = {32'h1B1B_050A, 2'b10, 20'h00002,
      58'h25A_5AC3_C3A5_A5F0};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic power_good = 1'b0;
   logic host_n = 1'b0;
   logic proc_n = 1'b0;
   logic mem_done = 1'b0;
   logic preq = 1'b0;
   logic [19:0] paddr = 20'h00000;
   logic [7:0] pdata = 8'h00;
   logic sclk, sout, soe, sin, sel0_n, sel1_n, fdone, loaded, fetch, ffl;
   logic lo0, lo1;
   logic fsck, fdo, wr_v;
   logic [19:0] wr_a;
   logic [7:0] wr_d;
   logic [39:0] fsr = '0;
   int nwr = 0;
   logic [4:0] v_oe, v_rb;
   logic [7:0] mult, hdiv, ddiv, sdiv;
   logic [57:0] mode;
   logic [10:0] cmd;
   int err_total = 0;
   int checks_done = 0;
   int n;
   wire [4:0] v_pin = ~v_oe;
   wire [2:0] evs = {fdone, fetch, loaded};
   always #5 ref_clk = ~ref_clk;

   power_on_config_rom_loader #(.RESET_SEQ_CYCLES(SEQ)) uut (
      .ref_clk, .rst_n, .power_good, .host_bus_reset_n(host_n),
      .processor_reset_n(proc_n), .mem_init_done(mem_done),
      .config_rom_serial_clock(sclk), .config_rom_serial_data_in(sin),
      .config_rom_serial_data_out(sout), .config_rom_serial_data_oe(soe),
      .boot_flash_select0_n(sel0_n), .boot_flash_select1_n(sel1_n),
      .boot_flash_serial_clock(fsck), .boot_flash_data_in(1'b1),
      .boot_flash_data_out(fdo), .core_voltage_code_in(v_pin),
      .core_voltage_code_out(), .core_voltage_code_oe(v_oe),
      .core_voltage_readback(v_rb), .vcode_load(1'b0),
      .vcode_value(5'h00), .flash_prog_req(preq),
      .flash_prog_addr(paddr), .flash_prog_data(pdata),
      .flash_prog_done(fdone), .core_multiplier_x2(mult),
      .host_bus_divisor(hdiv), .ddr_clock_divisor(ddiv),
      .sdr_clock_divisor(sdiv), .config_mode_bits(mode),
      .config_loaded(loaded), .mem_wr_valid(wr_v), .mem_wr_addr(wr_a),
      .mem_wr_data(wr_d), .internal_reset_active(), .first_fetch(fetch),
      .fetch_from_flash(ffl)
   );
   cfg_rom_model #(.IMAGE(IMG)) rom (
      .sclk, .data_out(sout), .data_oe(soe), .data_in(sin), .cmd
   );

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_sig(input int k, input int lim);
      n = 0;
      while (evs[k] !== 1'b1 && n < lim)
      begin
         @(negedge ref_clk);
         n++;
      end
   endtask

   task automatic end_sim();
      if (err_total == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(negedge ref_clk)
   begin
      if (!sel0_n)
         lo0 = 1'b1;
      if (!sel1_n)
         lo1 = 1'b1;
      if (wr_v)
         nwr++;
   end

   // Flash frames are captured on the serial clock rise, MSB first.
   always @(posedge fsck)
   begin
      fsr = {fsr[38:0], fdo};
   end

   initial
   begin
      #800000;
      err_total++;
      end_sim();
   end

   initial
   begin
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (12) @(negedge ref_clk);
      chk({loaded, soe, sclk, v_oe}, 8'h11);
      power_good = 1'b1;
      repeat (20) @(negedge ref_clk);
      chk(soe, 1'b0);
      host_n = 1'b1;
      wait_sig(0, 12000);
      chk(n >= 8928 && n < 8960, 1'b1);
      chk(cmd, 11'h600);
      chk({mult, hdiv, ddiv, sdiv}, IMG[111:80]);
      chk(mode, IMG[57:0]);
      chk(ffl, 1'b1);
      mem_done = 1'b1;
      proc_n = 1'b1;
      wait_sig(1, 2000);
      chk(n >= SEQ + 64 && n < 2000, 1'b1);
      chk(v_rb, 5'h0E);
      chk({nwr[7:0], wr_a, wr_d}, {8'h02, 20'h00001, 8'hFF});
      repeat (4) @(negedge ref_clk);
      lo0 = 1'b0;
      lo1 = 1'b0;
      paddr = 20'h80010;
      pdata = 8'hA5;
      preq = 1'b1;
      @(negedge ref_clk);
      preq = 1'b0;
      wait_sig(2, 3000);
      chk({n < 3000, lo0, lo1}, 3'b101);
      chk(fsr, 40'h02_0000_10A5);
      power_good = 1'b0;
      repeat (12) @(negedge ref_clk);
      chk({loaded, v_oe}, 6'h11);
      end_sim();
   end
endmodule // power_on_config_rom_loader_test

`default_nettype wire
